// *** hw/ccr_regs.sv ***
`timescale 1ns/1ps
module ccr_regs #(
  parameter logic [3:0] MAKER_CODE = 4'h5,     // arbitrary
  parameter logic [5:0] CORE_TYPE = 6'h15,     // arbitrary
  parameter logic [3:0] CORE_VER = 4'h3,       // arbitrary
  parameter logic [15:0] CORE_REV = 16'h0101,  // arbitrary
  parameter logic [31:0] SOC_ID = 32'h5a5a_0001 // arbitrary
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic spr_wr,
  input wire logic spr_rd,
  input wire logic [9:0] spr_num,
  input wire logic [31:0] spr_wdata,
  input wire logic guest_state_bit,
  input wire logic problem_state_bit,
  output logic [31:0] spr_rdata,
  output logic spr_ack,
  output logic priv_exc,
  output logic hyp_priv_exc,
  input wire logic [1:0] chip_number,
  input wire logic [1:0] soc_cluster_number,
  input wire logic [4:0] core_group_number,
  input wire logic [1:0] core_number_in_group,
  input wire logic ext_int_taken,
  input wire logic crit_int_taken,
  input wire logic reservation_set,
  output logic reservation_valid,
  input wire logic internal_error,
  output logic machine_check,
  input wire logic ext_tb_tick,
  output logic [63:0] time_base,
  input wire logic debug_int,
  output logic debug_to_dsave,
  output logic debug_to_csave,
  input wire logic upper_page_hw_write,
  input wire logic [31:0] upper_page_hw_data,
  output logic [31:0] upper_page_translation_reg,
  output logic dcache_flush_assist,
  output logic barrier_legacy,
  output logic uncached_guarded_ordering,
  output logic store_touch_nop,
  output logic cache_touch_nop,
  input wire logic db_req,
  input wire logic db_guest,
  input wire logic [31:0] db_tag,
  output logic db_hit,
  output logic gdb_hit
);

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic [31:0] impl_config_zero;
  logic [31:0] impl_config_one;
  logic [31:0] processor_tag;
  logic [31:0] guest_processor_tag;
  logic tag_loaded;
  logic hyp_ok;
  logic guest_sup;
  logic acc;
  logic [31:0] next_rdata;
  logic next_priv;
  logic next_hyp;
  logic [31:0] tag_pins;
  logic [31:0] core_version;

  assign hyp_ok = !guest_state_bit && !problem_state_bit;
  assign guest_sup = guest_state_bit && !problem_state_bit;
  assign acc = spr_wr || spr_rd;
  assign core_version = {MAKER_CODE, 2'b00, CORE_TYPE, CORE_VER, CORE_REV};
  assign tag_pins = (32'({chip_number}) << ccr_pkg::POS_CHIP)
    | (32'({soc_cluster_number}) << ccr_pkg::POS_SOCC)
    | (32'({core_group_number}) << ccr_pkg::POS_GRP)
    | (32'({core_number_in_group}) << ccr_pkg::POS_CORE);

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_priv = 1'b0;
    next_hyp = 1'b0;
    if (acc && problem_state_bit) begin
      next_priv = 1'b1;
    end else if (spr_rd) begin
      case (spr_num)
        ccr_pkg::SPR_CORE_VERSION: next_rdata = core_version;
        ccr_pkg::SPR_SOC_VERSION: next_rdata = SOC_ID;
        ccr_pkg::SPR_IMPL_CONFIG_ZERO: begin
          if (guest_sup) next_hyp = 1'b1;
          else next_rdata = impl_config_zero;
        end
        ccr_pkg::SPR_IMPL_CONFIG_ONE: begin
          if (guest_sup) next_hyp = 1'b1;
          else next_rdata = impl_config_one;
        end
        ccr_pkg::SPR_PROCESSOR_TAG: begin
          next_rdata = guest_sup ? guest_processor_tag : processor_tag;
        end
        ccr_pkg::SPR_GUEST_PROCESSOR_TAG: next_rdata = guest_processor_tag;
        default: next_rdata = 32'h0000_0000;
      endcase
    end else if (spr_wr && guest_sup) begin
      case (spr_num)
        ccr_pkg::SPR_PROCESSOR_TAG,
        ccr_pkg::SPR_GUEST_PROCESSOR_TAG,
        ccr_pkg::SPR_IMPL_CONFIG_ZERO,
        ccr_pkg::SPR_IMPL_CONFIG_ONE: next_hyp = 1'b1;
        default: next_hyp = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      spr_rdata <= 32'h0000_0000;
      spr_ack <= 1'b0;
      priv_exc <= 1'b0;
      hyp_priv_exc <= 1'b0;
    end else begin
      spr_rdata <= next_rdata;
      spr_ack <= acc;
      priv_exc <= next_priv;
      hyp_priv_exc <= next_hyp;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      impl_config_zero <= ccr_pkg::CFG0_RESET;
      impl_config_one <= ccr_pkg::CFG1_RESET;
    end else if (spr_wr && hyp_ok) begin
      if (spr_num == ccr_pkg::SPR_IMPL_CONFIG_ZERO) begin
        impl_config_zero <= spr_wdata & ccr_pkg::CFG0_IMPL_MASK;
      end
      if (spr_num == ccr_pkg::SPR_IMPL_CONFIG_ONE) begin
        impl_config_one <= spr_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // processor tags
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      processor_tag <= 32'h0000_0000;
      tag_loaded <= 1'b0;
    end else if (!tag_loaded) begin
      processor_tag <= tag_pins;
      tag_loaded <= 1'b1;
    end else if (spr_wr && hyp_ok && spr_num == ccr_pkg::SPR_PROCESSOR_TAG) begin
      processor_tag <= spr_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      guest_processor_tag <= ccr_pkg::GTAG_RESET;
    end else if (spr_wr && hyp_ok && spr_num == ccr_pkg::SPR_GUEST_PROCESSOR_TAG) begin
      guest_processor_tag <= spr_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      db_hit <= 1'b0;
      gdb_hit <= 1'b0;
    end else begin
      db_hit <= db_req && !db_guest && db_tag == processor_tag;
      gdb_hit <= db_req && db_guest && db_tag == guest_processor_tag;
    end
  end

  // ----------------------------------------------------------------
  // reservation and machine check
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reservation_valid <= 1'b0;
    end else if (reservation_set) begin
      reservation_valid <= 1'b1;
    end else if ((ext_int_taken || crit_int_taken) && impl_config_zero[ccr_pkg::POS_ICR]) begin
      reservation_valid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      machine_check <= 1'b0;
    end else begin
      machine_check <= internal_error && impl_config_zero[ccr_pkg::POS_INTERNAL_ERROR_CHECK_ENABLE];
    end
  end

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic [2:0] tick_sync;
  logic ext_edge;
  logic tb_step;
  logic tick_level;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tick_sync <= 3'h0;
      tick_level <= 1'b0;
    end else begin
      tick_sync <= {tick_sync[1:0], ext_tb_tick};
      // a level counts only once the last two stages agree
      if (tick_sync[2] == tick_sync[1]) begin
        tick_level <= tick_sync[2];
      end
    end
  end

  assign ext_edge = tick_sync[2] && tick_sync[1] && !tick_level;
  assign tb_step = impl_config_zero[ccr_pkg::POS_TBSEL] ? ext_edge : 1'b1;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      time_base <= 64'h0000_0000_0000_0000;
    end else if (impl_config_zero[ccr_pkg::POS_TIMEBASE_COUNT_ENABLE] && tb_step) begin
      time_base <= time_base + 64'h0000_0000_0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // debug, translation, cache and ordering controls
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      debug_to_dsave <= 1'b0;
      debug_to_csave <= 1'b0;
    end else begin
      debug_to_dsave <= debug_int && impl_config_zero[ccr_pkg::POS_DBG];
      debug_to_csave <= debug_int && !impl_config_zero[ccr_pkg::POS_DBG];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      upper_page_translation_reg <= 32'h0000_0000;
    end else if (upper_page_hw_write && impl_config_zero[ccr_pkg::POS_UPG]) begin
      upper_page_translation_reg <= upper_page_hw_data;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dcache_flush_assist <= 1'b0;
      barrier_legacy <= 1'b0;
      uncached_guarded_ordering <= 1'b0;
      store_touch_nop <= 1'b0;
      cache_touch_nop <= 1'b0;
    end else begin
      dcache_flush_assist <= impl_config_zero[ccr_pkg::POS_DCACHE_FLUSH_ASSIST];
      barrier_legacy <= impl_config_zero[ccr_pkg::POS_BAR];
      uncached_guarded_ordering <= impl_config_zero[ccr_pkg::POS_ORD];
      store_touch_nop <= impl_config_zero[ccr_pkg::POS_STN]
        || impl_config_zero[ccr_pkg::POS_CTN];
      cache_touch_nop <= impl_config_zero[ccr_pkg::POS_CTN];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  clear_resv_a: assert property (@(posedge ref_clk) disable iff (reset)
    (ext_int_taken || crit_int_taken) && !reservation_set && impl_config_zero[ccr_pkg::POS_ICR]
    |=> !reservation_valid) else $error("reservation not cleared");
  mcheck_a: assert property (@(posedge ref_clk) disable iff (reset)
    machine_check |-> $past(internal_error) && $past(impl_config_zero[ccr_pkg::POS_INTERNAL_ERROR_CHECK_ENABLE]))
    else $error("machine check without cause");
  tb_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    !impl_config_zero[ccr_pkg::POS_TIMEBASE_COUNT_ENABLE] |=> $stable(time_base))
    else $error("time base moved while disabled");
  tb_ext_a: assert property (@(posedge ref_clk) disable iff (reset)
    impl_config_zero[ccr_pkg::POS_TBSEL] && !ext_edge |=> $stable(time_base))
    else $error("time base moved without external tick");
  upg_block_a: assert property (@(posedge ref_clk) disable iff (reset)
    !impl_config_zero[ccr_pkg::POS_UPG] |=> $stable(upper_page_translation_reg))
    else $error("upper page updated while disabled");
  tag_guest_rd_a: assert property (@(posedge ref_clk) disable iff (reset)
    spr_rd && guest_sup && spr_num == ccr_pkg::SPR_PROCESSOR_TAG
    |=> spr_rdata == $past(guest_processor_tag)) else $error("guest tag read wrong");
  tag_wr_priv_a: assert property (@(posedge ref_clk) disable iff (reset)
    spr_wr && guest_sup && spr_num == ccr_pkg::SPR_PROCESSOR_TAG
    |=> hyp_priv_exc && $stable(processor_tag)) else $error("guest tag write allowed");
  prob_priv_a: assert property (@(posedge ref_clk) disable iff (reset)
    acc && problem_state_bit |=> priv_exc && !hyp_priv_exc)
    else $error("problem access not faulted");
  version_rd_a: assert property (@(posedge ref_clk) disable iff (reset)
    spr_rd && !problem_state_bit && spr_num == ccr_pkg::SPR_CORE_VERSION
    |=> spr_rdata[27:26] == 2'b00 && spr_rdata[15:0] == CORE_REV)
    else $error("core version read wrong");
  cfg_mask_a: assert property (@(posedge ref_clk) disable iff (reset)
    (impl_config_zero & ~ccr_pkg::CFG0_IMPL_MASK) == 32'h0000_0000)
    else $error("unimplemented config bit set");
  resv_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
    (ext_int_taken || crit_int_taken) && reservation_valid
    && !impl_config_zero[ccr_pkg::POS_ICR]
    |=> reservation_valid) else $error("reservation dropped with clearing off");
  dbg_route_a: assert property (@(posedge ref_clk) disable iff (reset)
    debug_int |=> debug_to_dsave == $past(impl_config_zero[ccr_pkg::POS_DBG])
    && debug_to_csave == !$past(impl_config_zero[ccr_pkg::POS_DBG]))
    else $error("debug save pair wrong");
  ctl_mirror_a: assert property (@(posedge ref_clk) disable iff (reset)
    dcache_flush_assist == $past(impl_config_zero[ccr_pkg::POS_DCACHE_FLUSH_ASSIST])
    && barrier_legacy == $past(impl_config_zero[ccr_pkg::POS_BAR])
    && uncached_guarded_ordering == $past(impl_config_zero[ccr_pkg::POS_ORD])
    && cache_touch_nop == $past(impl_config_zero[ccr_pkg::POS_CTN]))
    else $error("control output does not follow config");
  store_nop_a: assert property (@(posedge ref_clk) disable iff (reset)
    store_touch_nop == $past(impl_config_zero[ccr_pkg::POS_STN]
    || impl_config_zero[ccr_pkg::POS_CTN])) else $error("store touch no-op wrong");
  tag_reset_a: assert property (@(posedge ref_clk) disable iff (reset)
    tag_loaded && !$past(tag_loaded) |-> processor_tag == $past(tag_pins))
    else $error("processor tag not loaded from pins");
  tag_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    spr_wr && hyp_ok && tag_loaded && spr_num == ccr_pkg::SPR_PROCESSOR_TAG
    |=> processor_tag == $past(spr_wdata)) else $error("processor tag write lost");
  db_match_a: assert property (@(posedge ref_clk) disable iff (reset)
    db_req && !db_guest && db_tag == processor_tag |=> db_hit)
    else $error("doorbell for this core missed");
  gdb_match_a: assert property (@(posedge ref_clk) disable iff (reset)
    db_req && db_guest && db_tag == guest_processor_tag |=> gdb_hit)
    else $error("guest doorbell missed");
  cv_tb_c: cover property (@(posedge ref_clk) disable iff (reset)
    impl_config_zero[ccr_pkg::POS_TIMEBASE_COUNT_ENABLE] && tb_step);
  cv_db_c: cover property (@(posedge ref_clk) disable iff (reset) db_hit);
  cv_gdb_c: cover property (@(posedge ref_clk) disable iff (reset) gdb_hit);
  cv_hyp_c: cover property (@(posedge ref_clk) disable iff (reset) hyp_priv_exc);

endmodule

// *** hw/ccr_pkg.sv ***
package ccr_pkg;
  // special register numbers
  localparam logic [9:0] SPR_CORE_VERSION = 10'h11f;
  localparam logic [9:0] SPR_IMPL_CONFIG_ONE = 10'h3f1;
  localparam logic [9:0] SPR_IMPL_CONFIG_ZERO = 10'h3f0;
  localparam logic [9:0] SPR_PROCESSOR_TAG = 10'h11e;
  localparam logic [9:0] SPR_GUEST_PROCESSOR_TAG = 10'h17a;
  localparam logic [9:0] SPR_SOC_VERSION = 10'h3ff;
  // config zero field positions (32-bit view: bit n maps to 63-n)
  localparam int POS_ICR = 63 - 46;
  localparam int POS_INTERNAL_ERROR_CHECK_ENABLE = 63 - 48;
  localparam int POS_TIMEBASE_COUNT_ENABLE = 63 - 49;
  localparam int POS_TBSEL = 63 - 50;
  localparam int POS_DBG = 63 - 55;
  localparam int POS_UPG = 63 - 56;
  localparam int POS_DCACHE_FLUSH_ASSIST = 63 - 57;
  localparam int POS_BAR = 63 - 58;
  localparam int POS_ORD = 63 - 59;
  localparam int POS_STN = 63 - 61;
  localparam int POS_CTN = 63 - 63;
  localparam logic [31:0] CFG0_IMPL_MASK = 32'h0002_e1f5;
  localparam logic [31:0] CFG0_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG1_RESET = 32'h0000_0000;
  // tag field positions
  localparam int POS_CHIP = 63 - 51;
  localparam int POS_SOCC = 63 - 53;
  localparam int POS_GRP = 63 - 58;
  localparam int POS_CORE = 63 - 60;
  localparam logic [31:0] GTAG_RESET = 32'h0000_0000;
  // version fields
  localparam int POS_MAKER = 63 - 35;
  localparam int POS_TYPE = 63 - 43;
  localparam int POS_VER = 63 - 47;
endpackage

// *** tb/core_config_and_id_registers_tb.sv ***
`timescale 1ns/1ps
module core_config_and_id_registers_tb;
  logic ref_clk = 0;
  logic reset = 1;
  logic spr_wr = 0, spr_rd = 0, gs = 0, pr = 0, tick = 0, db_guest = 0;
  logic [9:0] spr_num = 10'h000;
  logic [31:0] spr_wdata = 32'h0, db_tag = 32'h0, upd = 32'h0;
  logic [6:0] ev = 7'h00;
  logic [1:0] strap_chip = 2'h2, strap_socc = 2'h1, strap_core = 2'h3;
  logic [4:0] strap_grp = 5'h13;
  logic [31:0] spr_rdata, upr, rd, ptag, gtag, d;
  logic spr_ack, priv_exc, hyp_priv_exc, res_v, mchk, dsv, csv, dbh, gdbh;
  logic [4:0] ctl;
  logic [63:0] time_base, t0;
  logic ak, pe, he;
  int n_errors = 0, cmp_count = 0;
  localparam logic [31:0] CVER = {4'ha, 2'b00, 6'h2c, 4'h6, 16'h0203};
  localparam logic [31:0] SOCV = 32'h1357_2468; // arbitrary
  always #5 ref_clk = ~ref_clk;
  ccr_regs #(.MAKER_CODE(4'ha), .CORE_TYPE(6'h2c), .CORE_VER(4'h6), .CORE_REV(16'h0203),
    .SOC_ID(SOCV)) dut_u (.ref_clk(ref_clk), .reset(reset), .spr_wr(spr_wr), .spr_rd(spr_rd),
    .spr_num(spr_num), .spr_wdata(spr_wdata), .guest_state_bit(gs), .problem_state_bit(pr),
    .spr_rdata(spr_rdata), .spr_ack(spr_ack), .priv_exc(priv_exc), .hyp_priv_exc(hyp_priv_exc),
    .chip_number(strap_chip), .soc_cluster_number(strap_socc), .core_group_number(strap_grp),
    .core_number_in_group(strap_core), .ext_int_taken(ev[0]), .crit_int_taken(ev[1]),
    .reservation_set(ev[2]), .reservation_valid(res_v), .internal_error(ev[3]),
    .machine_check(mchk), .ext_tb_tick(tick), .time_base(time_base), .debug_int(ev[4]),
    .debug_to_dsave(dsv), .debug_to_csave(csv), .upper_page_hw_write(ev[5]),
    .upper_page_hw_data(upd), .upper_page_translation_reg(upr), .dcache_flush_assist(ctl[4]),
    .barrier_legacy(ctl[3]), .uncached_guarded_ordering(ctl[2]), .store_touch_nop(ctl[1]),
    .cache_touch_nop(ctl[0]), .db_req(ev[6]), .db_guest(db_guest), .db_tag(db_tag),
    .db_hit(dbh), .gdb_hit(gdbh));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one access: request held for one edge, answer sampled in the following cycle
  task automatic acc(input logic w, input logic [9:0] n, input logic [31:0] dw,
                     input logic g, input logic p);
    @(posedge ref_clk);
    #1;
    spr_wr = w;
    spr_rd = !w;
    spr_num = n;
    spr_wdata = dw;
    gs = g;
    pr = p;
    @(posedge ref_clk);
    #1;
    spr_wr = 0;
    spr_rd = 0;
    rd = spr_rdata;
    ak = spr_ack;
    pe = priv_exc;
    he = hyp_priv_exc;
  endtask
  task automatic cfg(input logic [31:0] v);
    acc(1, ccr_pkg::SPR_IMPL_CONFIG_ZERO, v, 0, 0);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic fire(input int i);
    @(posedge ref_clk);
    #1;
    ev[i] = 1;
    @(posedge ref_clk);
    #1;
    ev[i] = 0;
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    end_of_test();
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    logic [4:0] e;
    logic g, p;
    repeat (10) @(posedge ref_clk);
    chk(time_base, 64'h0);
    chk({res_v, mchk, spr_ack, priv_exc, hyp_priv_exc}, 5'h00);
    #1;
    reset = 0;
    repeat (2) @(posedge ref_clk);
    ptag = (32'(strap_chip) << ccr_pkg::POS_CHIP) | (32'(strap_socc) << ccr_pkg::POS_SOCC) |
           (32'(strap_grp) << ccr_pkg::POS_GRP) | (32'(strap_core) << ccr_pkg::POS_CORE);
    acc(0, ccr_pkg::SPR_PROCESSOR_TAG, 0, 0, 0);
    chk({ak, rd}, {1'b1, ptag});
    acc(1, ccr_pkg::SPR_CORE_VERSION, 32'hffff_ffff, 0, 0);
    chk({pe, he}, 2'b00);
    acc(0, ccr_pkg::SPR_CORE_VERSION, 0, 0, 0);
    chk(rd, CVER);
    acc(1, ccr_pkg::SPR_SOC_VERSION, 32'h0, 0, 0);
    acc(0, ccr_pkg::SPR_SOC_VERSION, 0, 0, 0);
    chk(rd, SOCV);
    acc(0, 10'h001, 0, 0, 0);
    chk({ak, rd}, {1'b1, 32'h0});
    acc(1, ccr_pkg::SPR_IMPL_CONFIG_ONE, 32'h8421_c3a5, 0, 0);
    acc(0, ccr_pkg::SPR_IMPL_CONFIG_ONE, 0, 0, 0);
    chk(rd, 32'h8421_c3a5);
    acc(1, ccr_pkg::SPR_IMPL_CONFIG_ZERO, 32'hffff_ffff, 0, 0);
    acc(0, ccr_pkg::SPR_IMPL_CONFIG_ZERO, 0, 0, 0);
    chk(rd, ccr_pkg::CFG0_IMPL_MASK);
    // privilege matrix on both tags: problem, guest, guest problem, then hypervisor
    gtag = 32'h0000_0a5c;
    acc(1, ccr_pkg::SPR_GUEST_PROCESSOR_TAG, gtag, 0, 0);
    for (int i = 0; i < 4; i++) begin
      {g, p} = (i == 3) ? 2'b00 : 2'(i + 1);
      d = 32'h0000_0100 + 32'(i);
      acc(1, ccr_pkg::SPR_PROCESSOR_TAG, d, g, p);
      chk({ak, pe, he}, {1'b1, p, g & !p});
      if (!g && !p) ptag = d;
      acc(0, ccr_pkg::SPR_PROCESSOR_TAG, 0, g, p);
      chk({pe, rd}, {p, p ? 32'h0 : (g ? gtag : ptag)});
      acc(1, ccr_pkg::SPR_GUEST_PROCESSOR_TAG, d ^ 32'h0f00, g, p);
      chk({pe, he}, {p, g & !p});
      if (!g && !p) gtag = d ^ 32'h0f00;
      acc(0, ccr_pkg::SPR_GUEST_PROCESSOR_TAG, 0, g, p);
      chk({pe, he, rd}, {p, 1'b0, p ? 32'h0 : gtag});
    end
    // doorbells: own tag, foreign tag, guest tag
    for (int i = 0; i < 3; i++) begin
      db_guest = (i == 2);
      db_tag = (i == 0) ? ptag : ((i == 1) ? ptag ^ 32'h8 : gtag);
      fire(6);
      chk({dbh, gdbh}, {i == 0, i == 2});
    end
    // cache and ordering controls, one bit at a time
    for (int i = 0; i < 5; i++) begin
      e = 5'h10 >> i;
      cfg(32'h1 << ((i == 0) ? ccr_pkg::POS_DCACHE_FLUSH_ASSIST : (i == 1) ? ccr_pkg::POS_BAR :
          (i == 2) ? ccr_pkg::POS_ORD : (i == 3) ? ccr_pkg::POS_STN : ccr_pkg::POS_CTN));
      chk(ctl, (i == 4) ? 5'h03 : e);
    end
    // event controls disabled, then enabled
    for (int en = 0; en < 2; en++) begin
      cfg(en ? ((32'h1 << ccr_pkg::POS_ICR) | (32'h1 << ccr_pkg::POS_INTERNAL_ERROR_CHECK_ENABLE) |
          (32'h1 << ccr_pkg::POS_DBG) | (32'h1 << ccr_pkg::POS_UPG)) : 32'h0);
      fire(2);
      fire(en ? 1 : 0);
      chk(res_v, !en);
      fire(3);
      chk(mchk, en);
      fire(4);
      chk({dsv, csv}, {en == 1, en == 0});
      upd = 32'h0000_00c0 + 32'(en);
      fire(5);
      @(posedge ref_clk);
      #1;
      chk(upr, en ? upd : 32'h0);
    end
    // time base: internal rate counts every clock, held when disabled
    cfg(32'h1 << ccr_pkg::POS_TIMEBASE_COUNT_ENABLE);
    t0 = time_base;
    repeat (10) @(posedge ref_clk);
    #1;
    chk(time_base - t0, 64'h0a);
    cfg(32'h0);
    t0 = time_base;
    repeat (10) @(posedge ref_clk);
    #1;
    chk(time_base, t0);
    cfg((32'h1 << ccr_pkg::POS_TIMEBASE_COUNT_ENABLE) | (32'h1 << ccr_pkg::POS_TBSEL));
    repeat (6) @(posedge ref_clk);
    #1;
    t0 = time_base;
    for (int i = 0; i < 4; i++) begin
      repeat (3) @(posedge ref_clk);
      #1;
      tick = 1;
      repeat (3) @(posedge ref_clk);
      #1;
      tick = 0;
    end
    repeat (6) @(posedge ref_clk);
    #1;
    chk(time_base - t0, 64'h4);
    // second reset with new strap values: tag reloads, config returns to reset value
    strap_chip = 2'h1;
    strap_socc = 2'h2;
    strap_grp = 5'h0a;
    strap_core = 2'h0;
    reset = 1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(time_base, 64'h0);
    reset = 0;
    repeat (2) @(posedge ref_clk);
    ptag = (32'(strap_chip) << ccr_pkg::POS_CHIP) | (32'(strap_socc) << ccr_pkg::POS_SOCC) |
           (32'(strap_grp) << ccr_pkg::POS_GRP) | (32'(strap_core) << ccr_pkg::POS_CORE);
    acc(0, ccr_pkg::SPR_PROCESSOR_TAG, 0, 0, 0);
    chk({ak, rd}, {1'b1, ptag});
    acc(0, ccr_pkg::SPR_IMPL_CONFIG_ZERO, 0, 0, 0);
    chk(rd, ccr_pkg::CFG0_RESET);
    end_of_test();
  end
endmodule
